// file: mct_pkg.sv
// Package: register map, field layout and reset values of the match/capture counter-timer
package mct_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_COUNT  = 8'h04;
	localparam logic [7:0] OFS_PRESC  = 8'h08;
	localparam logic [7:0] OFS_PCOUNT = 8'h0c;
	localparam logic [7:0] OFS_MCTRL  = 8'h10;
	localparam logic [7:0] OFS_OCTRL  = 8'h14;
	localparam logic [7:0] OFS_CCTRL  = 8'h18;
	localparam logic [7:0] OFS_STAT   = 8'h1c;
	localparam logic [7:0] OFS_CLR    = 8'h20;
	localparam logic [7:0] OFS_IEN    = 8'h24;
	localparam logic [7:0] OFS_OUTS   = 8'h28;
	localparam logic [7:0] OFS_MATCH0 = 8'h30;
	localparam logic [7:0] OFS_CAPT0  = 8'h40;

	// Control register fields
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_RST_BIT   = 1;
	localparam int CTRL_MODE_LSB  = 2;
	localparam int CTRL_MODE_W    = 2;

	// Per-match control: three bits each (interrupt, reset, stop)
	localparam int MC_INT_BIT   = 0;
	localparam int MC_RST_BIT   = 1;
	localparam int MC_STOP_BIT  = 2;
	localparam int MC_FIELD_W   = 3;

	// Per-capture control: rise, fall, interrupt, clear-counter
	localparam int CC_RISE_BIT  = 0;
	localparam int CC_FALL_BIT  = 1;
	localparam int CC_INT_BIT   = 2;
	localparam int CC_CLR_BIT   = 3;
	localparam int CC_FIELD_W   = 4;

	// Status layout: matches in bits 3:0, captures in bits 5:4
	localparam int STAT_CAP_LSB = 4;
	localparam int STAT_W       = 6;

	// Output actions
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_LOW    = 2'h1;
	localparam logic [1:0] ACT_HIGH   = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	// Count source selection
	typedef enum logic [1:0] {
		MODE_TIMER   = 2'h0,
		MODE_CNT_RISE = 2'h1,
		MODE_CNT_FALL = 2'h2,
		MODE_CNT_BOTH = 2'h3
	} mode_t;

	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

// file: mct_edge_detect.sv
// Synchroniser and edge detector for one external input
`timescale 1ns/10ps
module mct_edge_detect (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Pin side
	input  wire logic pin,
	// Detected edges
	output logic      rise,
	output logic      fall
);

	logic sync1_ff;
	logic sync2_ff;
	logic prev_ff;
	logic nxt_sync1;
	logic nxt_sync2;
	logic nxt_prev;

	always_comb begin
		nxt_sync1 = pin;
		nxt_sync2 = sync1_ff;
		nxt_prev  = sync2_ff;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 1'h0;
			sync2_ff <= 1'h0;
			prev_ff  <= 1'h0;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			prev_ff  <= nxt_prev;
		end
	end

	// Only the second and third stages are looked at, never the metastable first one
	assign rise = sync2_ff & ~prev_ff;
	assign fall = ~sync2_ff & prev_ff;

endmodule

// file: mct_prescaler.sv
// Prescaler that issues a one-cycle count enable every limit+1 clocks
`timescale 1ns/10ps
module mct_prescaler #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// Control
	input  wire logic             run,
	input  wire logic             clear,
	input  wire logic [WIDTH-1:0] limit,
	// Status
	output logic      [WIDTH-1:0] value,
	output logic                  tick
);

	logic [WIDTH-1:0] pcnt_ff;
	logic [WIDTH-1:0] nxt_pcnt;

	assign tick  = run & ~clear & (pcnt_ff >= limit);
	assign value = pcnt_ff;

	always_comb begin
		nxt_pcnt = pcnt_ff;
		if (clear)
			nxt_pcnt = '0;
		else if (tick)
			nxt_pcnt = '0;
		else if (run)
			nxt_pcnt = pcnt_ff + WIDTH'(1);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			pcnt_ff <= '0;
		else
			pcnt_ff <= nxt_pcnt;
	end

endmodule

// file: match_capture_counter_timer.sv
// Match/capture counter-timer with APB register access
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - Counter and prescaler share parameter width
// - Timer mode counts prescaled clock cycles
// - Mode selects timer or external-event counting
// - Two capture channels latch counter on edge
// - Capture event may raise enabled interrupt
// - Capture may clear counter and prescaler
// - Four match registers compared on each count step
// - Match interrupt only when enabled, counter continues
// - Stop-on-match halts counting
// - Reset-on-match clears the counter
// - Match outputs go low, high, toggle, hold
module match_capture_counter_timer #(
	parameter int WIDTH = 32,
	parameter int NMATCH = 4,
	parameter int NCAP = 2
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// External event count input
	input  wire logic              count_in,
	// Capture inputs
	input  wire logic [NCAP-1:0]   capture_in,
	// Match outputs
	output logic      [NMATCH-1:0] match_out,
	// Interrupt
	output logic                   irq
);

	localparam int NSTAT = NMATCH + NCAP;

	// Registers
	logic                  en_ff;
	logic                  crst_ff;
	logic [1:0]            mode_ff;
	logic [WIDTH-1:0]      cnt_ff;
	logic [WIDTH-1:0]      presc_ff;
	logic [NMATCH*3-1:0]   mctrl_ff;
	logic [NMATCH*2-1:0]   octrl_ff;
	logic [NCAP*4-1:0]     cctrl_ff;
	logic [NSTAT-1:0]      stat_ff;
	logic [NSTAT-1:0]      ien_ff;
	logic [NMATCH-1:0]     mout_ff;
	logic [WIDTH-1:0]      match_ff [NMATCH];
	logic [WIDTH-1:0]      capt_ff  [NCAP];
	logic [31:0]           rdata_ff;

	logic                  nxt_en;
	logic                  nxt_crst;
	logic [1:0]            nxt_mode;
	logic [WIDTH-1:0]      nxt_cnt;
	logic [WIDTH-1:0]      nxt_presc;
	logic [NMATCH*3-1:0]   nxt_mctrl;
	logic [NMATCH*2-1:0]   nxt_octrl;
	logic [NCAP*4-1:0]     nxt_cctrl;
	logic [NSTAT-1:0]      nxt_stat;
	logic [NSTAT-1:0]      nxt_ien;
	logic [NMATCH-1:0]     nxt_mout;
	logic [WIDTH-1:0]      nxt_match [NMATCH];
	logic [WIDTH-1:0]      nxt_capt  [NCAP];
	logic [31:0]           nxt_rdata;

	// Bus decode
	logic                  wr_acc;
	logic                  rd_acc;
	logic                  addr_ok;

	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] base);
		is_reg = (a == base);
	endfunction

	// Byte addresses of match register i and capture register i
	function automatic logic [7:0] match_addr(input int i);
		match_addr = 8'(mct_pkg::OFS_MATCH0 + 8'(4 * i));
	endfunction

	function automatic logic [7:0] capt_addr(input int i);
		capt_addr = 8'(mct_pkg::OFS_CAPT0 + 8'(4 * i));
	endfunction

	assign pready  = 1'h1;
	assign wr_acc  = psel & penable & pwrite;
	// Reads latch in setup so prdata is settled through the access cycle
	assign rd_acc  = psel & ~penable & ~pwrite;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata  = rdata_ff;

	// Event sources
	logic [NCAP-1:0]       cap_rise;
	logic [NCAP-1:0]       cap_fall;
	logic                  ev_rise;
	logic                  ev_fall;
	logic                  ptick;
	logic [WIDTH-1:0]      pvalue;
	logic                  step;
	logic [NMATCH-1:0]     hit;
	logic [NCAP-1:0]       cap_ev;
	logic                  cap_clr;
	logic                  run;
	logic [NSTAT-1:0]      int_mask;

	genvar gi;
	generate
		for (gi = 0; gi < NCAP; gi++) begin : g_cap
			mct_edge_detect u_cap (
				.mclk (mclk),
				.rst  (rst),
				.pin  (capture_in[gi]),
				.rise (cap_rise[gi]),
				.fall (cap_fall[gi])
			);
			assign cap_ev[gi] =
				(cap_rise[gi] & cctrl_ff[gi*4+mct_pkg::CC_RISE_BIT]) |
				(cap_fall[gi] & cctrl_ff[gi*4+mct_pkg::CC_FALL_BIT]);
		end
		for (gi = 0; gi < NMATCH; gi++) begin : g_match
			// Compared only on cycles with a count step, so a match hits once per step at the matching value
			assign hit[gi] = en_ff & (cnt_ff == match_ff[gi]) & step;
		end
	endgenerate

	always_comb begin
		cap_clr = 1'h0;
		for (int i = 0; i < NCAP; i++)
			cap_clr = cap_clr | (cap_ev[i] & cctrl_ff[i*4+mct_pkg::CC_CLR_BIT]);
	end

	// Event input passes the same two-stage synchroniser as the captures
	mct_edge_detect u_evt (
		.mclk (mclk),
		.rst  (rst),
		.pin  (count_in),
		.rise (ev_rise),
		.fall (ev_fall)
	);

	assign run = en_ff & ~crst_ff;

	// Prescaler shares the counter width
	mct_prescaler #(
		.WIDTH (WIDTH)
	) u_presc (
		.mclk  (mclk),
		.rst   (rst),
		.run   (run & (mode_ff == mct_pkg::MODE_TIMER)),
		.clear (crst_ff | cap_clr),
		.limit (presc_ff),
		.value (pvalue),
		.tick  (ptick)
	);

	always_comb begin
		case (mode_ff)
			mct_pkg::MODE_TIMER:    step = ptick;
			mct_pkg::MODE_CNT_RISE: step = run & ev_rise;
			mct_pkg::MODE_CNT_FALL: step = run & ev_fall;
			mct_pkg::MODE_CNT_BOTH: step = run & (ev_rise | ev_fall);
			default:                step = 1'h0;
		endcase
	end

	// Counter, matches, captures and outputs
	always_comb begin
		logic any_rst;
		logic any_stop;
		any_rst  = 1'h0;
		any_stop = 1'h0;
		nxt_mout = mout_ff;
		for (int i = 0; i < NMATCH; i++) begin
			if (hit[i]) begin
				any_rst  = any_rst | mctrl_ff[i*3+mct_pkg::MC_RST_BIT];
				any_stop = any_stop | mctrl_ff[i*3+mct_pkg::MC_STOP_BIT];
				case (octrl_ff[i*2 +: 2])
					mct_pkg::ACT_LOW:    nxt_mout[i] = 1'h0;
					mct_pkg::ACT_HIGH:   nxt_mout[i] = 1'h1;
					mct_pkg::ACT_TOGGLE: nxt_mout[i] = ~mout_ff[i];
					default:             nxt_mout[i] = mout_ff[i];
				endcase
			end
		end
		nxt_cnt = cnt_ff;
		if (crst_ff | cap_clr)
			nxt_cnt = '0;
		else if (any_rst)
			nxt_cnt = '0;
		// A stopping match freezes the count at the matching value
		else if (step & ~any_stop)
			nxt_cnt = cnt_ff + WIDTH'(1);
		// A capture takes the count as it stands, before this cycle's step
		for (int i = 0; i < NCAP; i++)
			nxt_capt[i] = cap_ev[i] ? cnt_ff : capt_ff[i];

		// Register writes
		nxt_en    = en_ff;
		nxt_crst  = crst_ff;
		nxt_mode  = mode_ff;
		nxt_presc = presc_ff;
		nxt_mctrl = mctrl_ff;
		nxt_octrl = octrl_ff;
		nxt_cctrl = cctrl_ff;
		nxt_ien   = ien_ff;
		nxt_stat  = stat_ff;
		for (int i = 0; i < NMATCH; i++)
			nxt_match[i] = match_ff[i];
		if (wr_acc) begin
			if (is_reg(paddr, mct_pkg::OFS_CTRL)) begin
				nxt_en   = pwdata[mct_pkg::CTRL_EN_BIT];
				nxt_crst = pwdata[mct_pkg::CTRL_RST_BIT];
				nxt_mode = pwdata[mct_pkg::CTRL_MODE_LSB +: mct_pkg::CTRL_MODE_W];
			end
			if (is_reg(paddr, mct_pkg::OFS_PRESC))
				nxt_presc = pwdata[WIDTH-1:0];
			if (is_reg(paddr, mct_pkg::OFS_MCTRL))
				nxt_mctrl = pwdata[NMATCH*3-1:0];
			if (is_reg(paddr, mct_pkg::OFS_OCTRL))
				nxt_octrl = pwdata[NMATCH*2-1:0];
			if (is_reg(paddr, mct_pkg::OFS_CCTRL))
				nxt_cctrl = pwdata[NCAP*4-1:0];
			if (is_reg(paddr, mct_pkg::OFS_IEN))
				nxt_ien = pwdata[NSTAT-1:0];
			if (is_reg(paddr, mct_pkg::OFS_CLR))
				nxt_stat = stat_ff & ~pwdata[NSTAT-1:0];
			if (is_reg(paddr, mct_pkg::OFS_COUNT))
				nxt_cnt = pwdata[WIDTH-1:0];
			for (int i = 0; i < NMATCH; i++)
				if (is_reg(paddr, match_addr(i)))
					nxt_match[i] = pwdata[WIDTH-1:0];
		end
		// Hardware set wins over a same-cycle software clear
		// Every event is recorded; the interrupt bits only gate irq
		for (int i = 0; i < NMATCH; i++)
			if (hit[i])
				nxt_stat[i] = 1'h1;
		for (int i = 0; i < NCAP; i++)
			if (cap_ev[i])
				nxt_stat[mct_pkg::STAT_CAP_LSB + i] = 1'h1;
		if (any_stop)
			nxt_en = 1'h0;
	end

	// Read data mux, captured in setup phase
	always_comb begin
		nxt_rdata = rdata_ff;
		addr_ok   = 1'h0;
		if (is_reg(paddr, mct_pkg::OFS_CTRL) | is_reg(paddr, mct_pkg::OFS_COUNT) |
		    is_reg(paddr, mct_pkg::OFS_PRESC) | is_reg(paddr, mct_pkg::OFS_PCOUNT) |
		    is_reg(paddr, mct_pkg::OFS_MCTRL) | is_reg(paddr, mct_pkg::OFS_OCTRL) |
		    is_reg(paddr, mct_pkg::OFS_CCTRL) | is_reg(paddr, mct_pkg::OFS_STAT) |
		    is_reg(paddr, mct_pkg::OFS_CLR) | is_reg(paddr, mct_pkg::OFS_IEN) |
		    is_reg(paddr, mct_pkg::OFS_OUTS))
			addr_ok = 1'h1;
		for (int i = 0; i < NMATCH; i++)
			if (is_reg(paddr, match_addr(i)))
				addr_ok = 1'h1;
		for (int i = 0; i < NCAP; i++)
			if (is_reg(paddr, capt_addr(i)))
				addr_ok = 1'h1;
		if (rd_acc) begin
			nxt_rdata = 32'h0000_0000;
			case (paddr)
				mct_pkg::OFS_CTRL:   nxt_rdata = {28'h0, mode_ff, crst_ff, en_ff};
				mct_pkg::OFS_COUNT:  nxt_rdata = 32'(cnt_ff);
				mct_pkg::OFS_PRESC:  nxt_rdata = 32'(presc_ff);
				mct_pkg::OFS_PCOUNT: nxt_rdata = 32'(pvalue);
				mct_pkg::OFS_MCTRL:  nxt_rdata = 32'(mctrl_ff);
				mct_pkg::OFS_OCTRL:  nxt_rdata = 32'(octrl_ff);
				mct_pkg::OFS_CCTRL:  nxt_rdata = 32'(cctrl_ff);
				mct_pkg::OFS_STAT:   nxt_rdata = 32'(stat_ff);
				mct_pkg::OFS_IEN:    nxt_rdata = 32'(ien_ff);
				mct_pkg::OFS_OUTS:   nxt_rdata = 32'(mout_ff);
				default:             nxt_rdata = 32'h0000_0000;
			endcase
			for (int i = 0; i < NMATCH; i++)
				if (is_reg(paddr, match_addr(i)))
					nxt_rdata = 32'(match_ff[i]);
			for (int i = 0; i < NCAP; i++)
				if (is_reg(paddr, capt_addr(i)))
					nxt_rdata = 32'(capt_ff[i]);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en_ff    <= 1'h0;
			crst_ff  <= 1'h0;
			mode_ff  <= 2'h0;
			cnt_ff   <= '0;
			presc_ff <= '0;
			mctrl_ff <= '0;
			octrl_ff <= '0;
			cctrl_ff <= '0;
			stat_ff  <= '0;
			ien_ff   <= '0;
			mout_ff  <= '0;
			rdata_ff <= mct_pkg::RST_ZERO;
			for (int i = 0; i < NMATCH; i++)
				match_ff[i] <= '0;
			for (int i = 0; i < NCAP; i++)
				capt_ff[i] <= '0;
		end else begin
			en_ff    <= nxt_en;
			crst_ff  <= nxt_crst;
			mode_ff  <= nxt_mode;
			cnt_ff   <= nxt_cnt;
			presc_ff <= nxt_presc;
			mctrl_ff <= nxt_mctrl;
			octrl_ff <= nxt_octrl;
			cctrl_ff <= nxt_cctrl;
			stat_ff  <= nxt_stat;
			ien_ff   <= nxt_ien;
			mout_ff  <= nxt_mout;
			rdata_ff <= nxt_rdata;
			for (int i = 0; i < NMATCH; i++)
				match_ff[i] <= nxt_match[i];
			for (int i = 0; i < NCAP; i++)
				capt_ff[i] <= nxt_capt[i];
		end
	end

	// Per-source interrupt bits, laid out like the status register
	always_comb begin
		int_mask = '0;
		for (int i = 0; i < NMATCH; i++)
			int_mask[i] = mctrl_ff[i*3+mct_pkg::MC_INT_BIT];
		for (int i = 0; i < NCAP; i++)
			int_mask[mct_pkg::STAT_CAP_LSB + i] = cctrl_ff[i*4+mct_pkg::CC_INT_BIT];
	end

	assign match_out = mout_ff;
	// Needs both the enable register and the source's interrupt bit
	assign irq       = |(stat_ff & ien_ff & int_mask);

endmodule

// file: mct_assertions.sv
// Port-level assertions for the match/capture counter-timer
`timescale 1ns/10ps
module mct_assertions #(
	parameter int WIDTH  = 32,
	parameter int NMATCH = 4,
	parameter int NCAP   = 2
) (
	// Clock and reset
	input wire logic              mclk,
	input wire logic              rst,
	// APB slave
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Pins
	input wire logic              count_in,
	input wire logic [NCAP-1:0]   capture_in,
	input wire logic [NMATCH-1:0] match_out,
	input wire logic              irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic wr_acc;
	assign wr_acc = psel & penable & pwrite;

	a_ready_always: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_unmapped_err: assert property (psel && penable && paddr == 8'h2c
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && penable && paddr == mct_pkg::OFS_MATCH0 |-> !pslverr)
		else $error("mapped access refused");
	a_stat_width: assert property (
		psel && penable && !pwrite && paddr == mct_pkg::OFS_STAT |-> prdata[31:6] == 26'h0)
		else $error("status reads beyond six event bits");
	a_irq_mask_off: assert property (
		wr_acc && paddr == mct_pkg::OFS_IEN && pwdata[5:0] == 6'h0 |=> !irq)
		else $error("irq high with all enables off");
	a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_acc))
		else $error("irq fell without a register write");
	a_out_quiet_reset: assert property ($fell(rst) |-> match_out == '0 && !irq)
		else $error("outputs not idle after reset");
endmodule

bind match_capture_counter_timer mct_assertions #(
	.WIDTH(WIDTH), .NMATCH(NMATCH), .NCAP(NCAP)
) u_mct_assertions (
	.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .count_in(count_in), .capture_in(capture_in),
	.match_out(match_out), .irq(irq)
);

// file: test_match_capture_counter_timer.sv
// Self-checking bench for the match/capture counter-timer
`timescale 1ns/10ps
module test_match_capture_counter_timer;
	logic        mclk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        count_in;
	logic [1:0]  capture_in;
	logic [3:0]  match_out;
	logic        irq;
	int          miscompares;
	int          checks;
	integer      seed;
	logic [31:0] rd;
	logic        err;
	logic [31:0] c1;
	logic [3:0]  eo;
	int          m;
	int          p;
	int          k;
	int          i;

	match_capture_counter_timer dut (
		.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_in(count_in), .capture_in(capture_in),
		.match_out(match_out), .irq(irq)
	);

	initial mclk = 1'b0;
	always #25 mclk = ~mclk;

	// Output level expected after one match with the given action
	function automatic logic act_out(input logic [1:0] a, input logic cur);
		case (a)
			mct_pkg::ACT_LOW:    return 1'b0;
			mct_pkg::ACT_HIGH:   return 1'b1;
			mct_pkg::ACT_TOGGLE: return ~cur;
			default:             return cur;
		endcase
	endfunction

	// Edges counted for n input pulses in the given count mode
	function automatic logic [31:0] ev_count(input logic [1:0] md, input int n);
		return (md == mct_pkg::MODE_CNT_BOTH) ? 32'(2 * n) : 32'(n);
	endfunction

	task automatic check(input logic ok);
		checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("BAD at %0t: mismatch in check %0d", $time, checks);
		end
	endtask

	// One APB transfer; an idle edge first keeps drives one per time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_irq(input int n);
		for (int j = 0; j < n && irq !== 1'b1; j++) @(negedge mclk);
	endtask

	task automatic complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Whole run needs well under 2000 cycles
	initial begin
		#1000000;
		miscompares++;
		complete_run();
	end

	initial begin
		seed = 6;
		miscompares = 0;
		checks = 0;
		rst = 1'b1;
		{psel, penable, pwrite, count_in} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		capture_in = 2'b00;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		apb(0, mct_pkg::OFS_STAT, 0);
		check(rd === 32'h0);
		apb(0, 8'h2c, 0);
		check(err === 1'b1 && rd === 32'h0);
		// All four matches hit together; match 0 stops the count
		m = 5 + ($unsigned($random(seed)) % 16);
		apb(1, mct_pkg::OFS_PRESC, 32'h1);
		for (i = 0; i < 4; i++) apb(1, mct_pkg::OFS_MATCH0 + 8'(4 * i), m);
		apb(1, mct_pkg::OFS_OCTRL, 32'h0b);
		apb(1, mct_pkg::OFS_MCTRL, 32'h5);
		apb(1, mct_pkg::OFS_IEN, 32'h1);
		apb(1, mct_pkg::OFS_CTRL, 32'h1);
		wait_irq(4 * m + 40);
		check(irq === 1'b1);
		apb(0, mct_pkg::OFS_COUNT, 0);
		check(rd === 32'(m));
		apb(0, mct_pkg::OFS_CTRL, 0);
		check(rd[0] === 1'b0);
		apb(0, mct_pkg::OFS_STAT, 0);
		check(rd[3:0] === 4'hf);
		eo = {act_out(mct_pkg::ACT_NONE, 0), act_out(mct_pkg::ACT_NONE, 0),
			act_out(mct_pkg::ACT_HIGH, 0), act_out(mct_pkg::ACT_TOGGLE, 0)};
		check(match_out === eo);
		apb(0, mct_pkg::OFS_OUTS, 0);
		check(rd === 32'(eo));
		apb(1, mct_pkg::OFS_CLR, 32'h3f);
		@(negedge mclk);
		check(irq === 1'b0);
		// Prescaled rate over a 40-cycle span
		p = 1 + ($unsigned($random(seed)) % 3);
		apb(1, mct_pkg::OFS_MCTRL, 32'h0);
		apb(1, mct_pkg::OFS_CTRL, 32'h2);
		apb(1, mct_pkg::OFS_PRESC, p);
		apb(1, mct_pkg::OFS_CTRL, 32'h1);
		apb(0, mct_pkg::OFS_COUNT, 0);
		c1 = rd;
		repeat (37) @(posedge mclk);
		apb(0, mct_pkg::OFS_COUNT, 0);
		k = int'(rd - c1);
		check(k >= 40 / (p + 1) - 1 && k <= 40 / (p + 1) + 1);
		apb(0, mct_pkg::OFS_PCOUNT, 0);
		check(rd <= 32'(p));
		// Reset on match 1 with its interrupt masked
		apb(1, mct_pkg::OFS_IEN, 32'h0);
		apb(1, mct_pkg::OFS_PRESC, 32'h0);
		apb(1, mct_pkg::OFS_MCTRL, 32'h10);
		apb(1, mct_pkg::OFS_OCTRL, 32'h04);
		apb(1, mct_pkg::OFS_CTRL, 32'h2);
		apb(1, mct_pkg::OFS_CLR, 32'h3f);
		apb(1, mct_pkg::OFS_CTRL, 32'h1);
		for (i = 0; i < 12; i++) begin
			apb(0, mct_pkg::OFS_COUNT, 0);
			check(rd <= 32'(m));
		end
		apb(0, mct_pkg::OFS_STAT, 0);
		check(rd[1] === 1'b1 && irq === 1'b0);
		check(match_out[1] === act_out(mct_pkg::ACT_LOW, 1'b1));
		// Capture 0 on rise with interrupt, capture 1 clears on fall
		apb(1, mct_pkg::OFS_MCTRL, 32'h0);
		apb(1, mct_pkg::OFS_CCTRL, 32'ha5);
		apb(1, mct_pkg::OFS_IEN, 32'h10);
		apb(1, mct_pkg::OFS_CLR, 32'h3f);
		apb(1, mct_pkg::OFS_CTRL, 32'h2);
		apb(1, mct_pkg::OFS_CTRL, 32'h1);
		repeat (30) @(posedge mclk);
		capture_in <= 2'b11;
		wait_irq(10);
		check(irq === 1'b1);
		apb(0, mct_pkg::OFS_STAT, 0);
		check(rd[5:4] === 2'b01);
		apb(0, mct_pkg::OFS_CAPT0, 0);
		check(rd >= 32'd30 && rd <= 32'd38);
		apb(0, mct_pkg::OFS_COUNT, 0);
		c1 = rd;
		capture_in <= 2'b01;
		repeat (4) @(posedge mclk);
		apb(0, mct_pkg::OFS_COUNT, 0);
		check(c1 > 32'd30 && rd < 32'd10);
		apb(0, mct_pkg::OFS_CAPT0 + 8'h04, 0);
		check(rd >= c1 && rd < c1 + 32'd10);
		// Event counting on rising, falling and both edges of the count input
		k = 1 + ($unsigned($random(seed)) % 8);
		apb(1, mct_pkg::OFS_CCTRL, 32'h0);
		for (i = 1; i < 4; i++) begin
			apb(1, mct_pkg::OFS_CTRL, 32'h2 | 32'(i << 2));
			apb(1, mct_pkg::OFS_CTRL, 32'h1 | 32'(i << 2));
			repeat (10) @(posedge mclk);
			apb(0, mct_pkg::OFS_COUNT, 0);
			check(rd === 32'h0);
			for (p = 0; p < k; p++) begin
				count_in <= 1'b1;
				repeat (4) @(posedge mclk);
				count_in <= 1'b0;
				repeat (4) @(posedge mclk);
			end
			apb(0, mct_pkg::OFS_COUNT, 0);
			check(rd === ev_count(i[1:0], k));
		end
		complete_run();
	end
endmodule
